/* rtl/gpm_defs.svh */
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH

// ==========================================================
// Register map (byte addresses)
`define GPM_ADDR_W 5
`define GPM_OFF_FUNC_LO 5'h00
`define GPM_OFF_FUNC_HI 5'h04
`define GPM_OFF_OUT_DATA 5'h08
`define GPM_OFF_PIN_IN 5'h0C
`define GPM_OFF_STATUS 5'h10

// ==========================================================
// Field layout and reset values
`define GPM_NUM_PINS 17
`define GPM_FIRST_PIN 5
`define GPM_NUM_ALARM 9
`define GPM_FUNC_BITS 34
`define GPM_FUNC_RST 34'h0_0000_0000
`define GPM_OUT_RST 17'h0_0000
`define GPM_ERR_PIN_IDX 1
`define GPM_UPD_PIN_IDX 3
`define GPM_RESP_OKAY 2'h0
`define GPM_RESP_SLVERR 2'h2

// ==========================================================
// Timing
`define GPM_CLK_PERIOD_NS 8
`define GPM_MIN_PHASE_NS 500
`define GPM_MIN_PHASE_CYC ((`GPM_MIN_PHASE_NS + `GPM_CLK_PERIOD_NS - 1) / `GPM_CLK_PERIOD_NS)
`define GPM_CNT_W 7

`endif

/* rtl/gpm_pkg.sv */
package gpm_pkg;
  // Per-pin function select
  typedef enum logic [1:0] {
    GPM_FUNC_INPUT = 2'h0,
    GPM_FUNC_GPOUT = 2'h1,
    GPM_FUNC_ALARM = 2'h2,
    GPM_FUNC_SPECIAL = 2'h3
  } gpm_func_e;
endpackage

/* rtl/gpm_phase_filter.sv */
`include "gpm_defs.svh"

module gpm_phase_filter (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control and pin
  input wire logic enable,
  input wire logic raw_in,
  // Qualified result
  output logic level_out,
  output logic rise_pulse
);
  import gpm_pkg::*;

  localparam logic [`GPM_CNT_W-1:0] MIN_CYC = `GPM_CNT_W'(`GPM_MIN_PHASE_CYC);

  logic raw_d_reg, raw_d_next;
  logic level_reg, level_next;
  logic pulse_reg, pulse_next;
  logic [`GPM_CNT_W-1:0] cnt_reg, cnt_next;

  // ==========================================================
  // Phase qualification: a level counts only once it has stood long enough
  always_comb
  begin
    raw_d_next = raw_in;
    cnt_next = cnt_reg;
    level_next = level_reg;
    pulse_next = 1'b0;
    if (!enable)
    begin
      cnt_next = '0;
      level_next = raw_d_reg;
    end
    else if (raw_in != raw_d_reg)
      cnt_next = `GPM_CNT_W'(1);
    else if (cnt_reg < MIN_CYC)
      cnt_next = cnt_reg + `GPM_CNT_W'(1);
    if (enable && cnt_reg >= MIN_CYC && raw_d_reg != level_reg)
    begin
      level_next = raw_d_reg;
      pulse_next = raw_d_reg;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raw_d_reg <= 1'b0;
      cnt_reg <= '0;
      level_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      raw_d_reg <= raw_d_next;
      cnt_reg <= cnt_next;
      level_reg <= level_next;
      pulse_reg <= pulse_next;
    end
  end

  assign level_out = level_reg;
  assign rise_pulse = pulse_reg;

endmodule // gpm_phase_filter

/* rtl/gpm_pin_mux.sv */
// Functional notes
// - All pins come out of reset as undriven inputs
// - Each pin selects GPIO or its port alarm
// - Pins 5 and 6 show port 3 alarm
// - Pins 7 and 8 show port 4 alarm
// - Pins 9 and 10 show port 5 alarm
// - Pins 11 and 12 show port 6 alarm
// - Pins 13 and 14 show port 7 alarm
// - Pins 15 and 16 show port 8 alarm
// - Pins 17 and 18 show port 9 alarm
// - Pins 19 and 20 show port 10 alarm
// - Pin 21 shows port 11 alarm
// - Pin 6 may be error insert input, phases over 500 ns
// - Pin 8 may be counter update input, phases over 500 ns
`include "gpm_defs.svh"

module gpm_pin_mux (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [`GPM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`GPM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Alarm indications of ports 3 to 11
  input wire logic [`GPM_NUM_ALARM-1:0] port_alarm,
  // Pins 5 to 21, index 0 is pin 5
  input wire logic [`GPM_NUM_PINS-1:0] pin_in,
  output logic [`GPM_NUM_PINS-1:0] pin_out,
  output logic [`GPM_NUM_PINS-1:0] pin_oe,
  // Qualified special inputs
  output logic error_insert_input,
  output logic error_insert_pulse,
  output logic counter_update_input,
  output logic counter_update_pulse
);
  import gpm_pkg::*;

  // ==========================================================
  // Register state
  logic [`GPM_FUNC_BITS-1:0] func_reg, func_next;
  logic [`GPM_NUM_PINS-1:0] out_data_reg, out_data_next;
  logic [`GPM_NUM_PINS-1:0] pin_out_reg, pin_out_next;
  logic [`GPM_NUM_PINS-1:0] pin_oe_reg, pin_oe_next;
  logic [`GPM_NUM_PINS-1:0] pin_in_reg;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [`GPM_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_level, err_pulse, upd_level, upd_pulse;
  logic err_en, upd_en;
  logic [`GPM_NUM_PINS-1:0] alarm_of_pin;

  // ==========================================================
  // Alarm source of each pin
  always_comb
  begin
    alarm_of_pin[0] = port_alarm[0];
    alarm_of_pin[1] = port_alarm[0];
    alarm_of_pin[2] = port_alarm[1];
    alarm_of_pin[3] = port_alarm[1];
    alarm_of_pin[4] = port_alarm[2];
    alarm_of_pin[5] = port_alarm[2];
    alarm_of_pin[6] = port_alarm[3];
    alarm_of_pin[7] = port_alarm[3];
    alarm_of_pin[8] = port_alarm[4];
    alarm_of_pin[9] = port_alarm[4];
    alarm_of_pin[10] = port_alarm[5];
    alarm_of_pin[11] = port_alarm[5];
    alarm_of_pin[12] = port_alarm[6];
    alarm_of_pin[13] = port_alarm[6];
    alarm_of_pin[14] = port_alarm[7];
    alarm_of_pin[15] = port_alarm[7];
    alarm_of_pin[16] = port_alarm[8];
  end

  // ==========================================================
  // Pin drivers; special mode on pins without one stays an input
  always_comb
  begin
    pin_out_next = '0;
    pin_oe_next = '0;
    for (int i = 0; i < `GPM_NUM_PINS; i++)
    begin
      unique case (gpm_func_e'(func_reg[2*i +: 2]))
        GPM_FUNC_GPOUT:
        begin
          pin_out_next[i] = out_data_reg[i];
          pin_oe_next[i] = 1'b1;
        end
        GPM_FUNC_ALARM:
        begin
          pin_out_next[i] = alarm_of_pin[i];
          pin_oe_next[i] = 1'b1;
        end
        GPM_FUNC_INPUT, GPM_FUNC_SPECIAL:
        begin
          pin_out_next[i] = 1'b0;
          pin_oe_next[i] = 1'b0;
        end
      endcase
    end
  end

  assign err_en = func_reg[2*`GPM_ERR_PIN_IDX +: 2] == GPM_FUNC_SPECIAL;
  assign upd_en = func_reg[2*`GPM_UPD_PIN_IDX +: 2] == GPM_FUNC_SPECIAL;

  // ==========================================================
  // Special input qualification
  gpm_phase_filter u_err_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(err_en),
    .raw_in(pin_in[`GPM_ERR_PIN_IDX]),
    .level_out(err_level),
    .rise_pulse(err_pulse)
  );

  gpm_phase_filter u_upd_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(upd_en),
    .raw_in(pin_in[`GPM_UPD_PIN_IDX]),
    .level_out(upd_level),
    .rise_pulse(upd_pulse)
  );

  // ==========================================================
  // AXI4-Lite slave
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    func_next = func_reg;
    out_data_next = out_data_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && !aw_held_reg)
    begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_next = 1'b0;
    if (aw_held_reg && w_held_reg && !bvalid_reg)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `GPM_RESP_OKAY;
      unique case (awaddr_reg)
        `GPM_OFF_FUNC_LO:
          for (int b = 0; b < 4; b++)
            if (wstrb_reg[b])
              func_next[8*b +: 8] = wdata_reg[8*b +: 8];
        `GPM_OFF_FUNC_HI:
          if (wstrb_reg[0])
            func_next[33:32] = wdata_reg[1:0];
        `GPM_OFF_OUT_DATA:
        begin
          for (int b = 0; b < 2; b++)
            if (wstrb_reg[b])
              out_data_next[8*b +: 8] = wdata_reg[8*b +: 8];
          if (wstrb_reg[2])
            out_data_next[16] = wdata_reg[16];
        end
        `GPM_OFF_PIN_IN, `GPM_OFF_STATUS: ;
        default: bresp_next = `GPM_RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next = `GPM_RESP_OKAY;
      unique case (s_axi_araddr)
        `GPM_OFF_FUNC_LO: rdata_next = func_reg[31:0];
        `GPM_OFF_FUNC_HI: rdata_next = {30'h0000_0000, func_reg[33:32]};
        `GPM_OFF_OUT_DATA: rdata_next = {15'h0000, out_data_reg};
        `GPM_OFF_PIN_IN: rdata_next = {15'h0000, pin_in_reg};
        `GPM_OFF_STATUS: rdata_next = {30'h0000_0000, upd_level, err_level};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = `GPM_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      func_reg <= `GPM_FUNC_RST;
      out_data_reg <= `GPM_OUT_RST;
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      pin_in_reg <= '0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `GPM_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `GPM_RESP_OKAY;
      rdata_reg <= '0;
    end
    else
    begin
      func_reg <= func_next;
      out_data_reg <= out_data_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      pin_in_reg <= pin_in;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign error_insert_input = err_level;
  assign error_insert_pulse = err_pulse;
  assign counter_update_input = upd_level;
  assign counter_update_pulse = upd_pulse;

  // ==========================================================
  // Checks
  reset_input_a: assert property (@(posedge aclk) !aresetn |=> pin_oe == '0)
    else $error("pins driven after reset");
  gpio_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func_reg[1:0] == GPM_FUNC_GPOUT |=> pin_oe[0] && pin_out[0] == $past(out_data_reg[0]))
    else $error("pin 5 not driving output data");
  alarm_pin5_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func_reg[1:0] == GPM_FUNC_ALARM |=> pin_out[0] == $past(port_alarm[0]))
    else $error("pin 5 not showing port 3 alarm");
  alarm_pin8_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func_reg[7:6] == GPM_FUNC_ALARM |=> pin_out[3] == $past(port_alarm[1]))
    else $error("pin 8 not showing port 4 alarm");
  alarm_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func_reg[17:16] == GPM_FUNC_ALARM && func_reg[19:18] == GPM_FUNC_ALARM |=> pin_out[8] == pin_out[9])
    else $error("pins 13 and 14 disagree");
  alarm_pin21_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func_reg[33:32] == GPM_FUNC_ALARM |=> pin_oe[16] && pin_out[16] == $past(port_alarm[8]))
    else $error("pin 21 not showing port 11 alarm");
  err_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(error_insert_pulse) |-> $past(pin_in[1], 2) && $past(pin_in[1], 64))
    else $error("error insert accepted on short phase");
  upd_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(counter_update_pulse) |-> $past(pin_in[3], 2) && $past(pin_in[3], 64))
    else $error("counter update accepted on short phase");
  err_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(error_insert_input) && $past(err_en) |-> !$past(pin_in[1], 2) && !$past(pin_in[1], 64))
    else $error("error insert low accepted on short phase");
  upd_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(counter_update_input) && $past(upd_en) |-> !$past(pin_in[3], 2) && !$past(pin_in[3], 64))
    else $error("counter update low accepted on short phase");
  special_undriven_a: assert property (@(posedge aclk) disable iff (!aresetn)
    err_en |=> !pin_oe[1])
    else $error("pin 6 driven in error insert mode");

endmodule // gpm_pin_mux

/* testbench/gpm_board.sv */
// ==========================================
// Board side of the pins
module gpm_board (
  // Device side
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe,
  // Board source
  input wire logic drv_en,
  input wire logic [16:0] drv_val,
  // Wire level
  output logic [16:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device drive wins, else board source, else pull-up
  assign pin_in = (pin_out & pin_oe) | (~pin_oe & (drv_en ? drv_val : 17'h1_FFFF));
endmodule // gpm_board

/* testbench/general_pin_function_mux_tb.sv */
`include "gpm_defs.svh"
module general_pin_function_mux_tb import gpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [`GPM_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [8:0] alarm;
  logic [16:0] pin_in, pin_out, pin_oe, drv_val, od;
  logic drv_en, eil, eip, cul, cup;
  int error_cnt, tests_run, cyc, seed, k, pe, pu;
  int fn[17];

  gpm_pin_mux u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_alarm(alarm), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .error_insert_input(eil), .error_insert_pulse(eip),
    .counter_update_input(cul), .counter_update_pulse(cup));
  gpm_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));

  // ==========================================
  // Clock and timeout
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [`GPM_ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [`GPM_ADDR_W-1:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic prog();
    logic [31:0] lo;
    lo = 32'h0;
    for (int j = 0; j < 16; j++) lo[2*j +: 2] = fn[j][1:0];
    wr(`GPM_OFF_FUNC_LO, lo);
    wr(`GPM_OFF_FUNC_HI, {30'h0, fn[16][1:0]});
    chk(r, `GPM_RESP_OKAY, "write resp");
    rd(`GPM_OFF_FUNC_LO);
    chk(r, `GPM_RESP_OKAY, "read resp");
    chk(d, lo, "func readback");
    rd(`GPM_OFF_FUNC_HI);
    chk(d, {30'h0, fn[16][1:0]}, "func hi readback");
  endtask
  task automatic pins();
    repeat (3) @(posedge aclk);
    for (int j = 0; j < 17; j++)
    begin
      chk(pin_oe[j], fn[j] == GPM_FUNC_GPOUT || fn[j] == GPM_FUNC_ALARM, "pin drive");
      if (fn[j] == GPM_FUNC_GPOUT) chk(pin_out[j], od[j], "gpio level");
      if (fn[j] == GPM_FUNC_ALARM) chk(pin_out[j], alarm[j / 2], "alarm");
    end
  endtask
  task automatic hold(input logic v, input int n);
    @(posedge aclk);
    drv_val <= v ? 17'h1_FFFF : 17'h0;
    pe = 0;
    pu = 0;
    repeat (n)
    begin
      @(posedge aclk);
      pe += (eip === 1'b1);
      pu += (cup === 1'b1);
    end
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    seed = 32'hc4bd8e97;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, drv_en} = 7'h00;
    {awaddr, araddr, wdata, alarm, drv_val} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(pin_oe, 17'h0, "reset drive");
    rd(`GPM_OFF_FUNC_LO);
    chk(d, 32'h0, "reset func");
    $display("test reset done");
    for (k = 0; k < 8; k++)
    begin
      foreach (fn[j]) fn[j] = (k < 2) ? k + 1 : $random(seed) & 3;
      od = 17'($random(seed));
      alarm <= 9'($random(seed));
      prog();
      wr(`GPM_OFF_OUT_DATA, {15'h0, od});
      pins();
    end
    $display("test functions done");
    rd(5'h14);
    chk(r, `GPM_RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    wr(5'h14, 32'hFFFF_FFFF);
    chk(r, `GPM_RESP_SLVERR, "unmapped write resp");
    wstrb <= 4'h2;
    wr(`GPM_OFF_OUT_DATA, 32'h0000_0000);
    wstrb <= 4'hF;
    rd(`GPM_OFF_OUT_DATA);
    chk(d, {15'h0, od & 17'h1_00FF}, "byte strobe");
    foreach (fn[j]) fn[j] = GPM_FUNC_INPUT;
    prog();
    drv_en <= 1'b1;
    drv_val <= 17'($random(seed));
    repeat (4) @(posedge aclk);
    rd(`GPM_OFF_PIN_IN);
    chk(d, {15'h0, drv_val}, "pin input");
    $display("test inputs done");
    fn[`GPM_ERR_PIN_IDX] = GPM_FUNC_SPECIAL;
    fn[`GPM_UPD_PIN_IDX] = GPM_FUNC_SPECIAL;
    prog();
    hold(1'b0, 100);
    hold(1'b1, 30);
    chk({pe[7:0], pu[7:0], 7'h0, eil, 7'h0, cul}, 32'h0, "short phase");
    hold(1'b0, 100);
    hold(1'b1, 100);
    chk({pe[7:0], pu[7:0], 7'h0, eil, 7'h0, cul}, 32'h0101_0101, "long high");
    rd(`GPM_OFF_STATUS);
    chk(d[1:0], 2'h3, "status");
    hold(1'b0, 100);
    chk({pe[7:0], pu[7:0], 7'h0, eil, 7'h0, cul}, 32'h0, "long low");
    $display("test special inputs done");
    foreach (fn[j]) fn[j] = GPM_FUNC_GPOUT;
    prog();
    repeat (2) @(posedge aclk);
    chk(pin_oe, 17'h1_FFFF, "all driven");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(pin_oe, 17'h0, "second reset drive");
    rd(`GPM_OFF_FUNC_HI);
    chk(d, 32'h0, "second reset func");
    $display("test second reset done");
    report_and_stop();
  end
endmodule // general_pin_function_mux_tb
